// File: src/smrc_defs.svh
`ifndef SMRC_DEFS_SVH
`define SMRC_DEFS_SVH

// ==========================================================================
// command and mode register layout
`define SMRC_ADDR_W        18
`define SMRC_SEL_ONE       2'h1
`define SMRC_SEL_TWO       2'h2
`define SMRC_ONE_QOFF      12
`define SMRC_ONE_TSTROBE   11
`define SMRC_ONE_WLEVEL    7
`define SMRC_ONE_ADDLAT_HI 4
`define SMRC_ONE_ADDLAT_LO 3
`define SMRC_TWO_AUTOSR    6
`define SMRC_TWO_WCL_HI    5
`define SMRC_TWO_WCL_LO    3
`define SMRC_TWO_WTERM_HI  10
`define SMRC_TWO_WTERM_LO  9

// ==========================================================================
// timing
`define SMRC_WCL_BASE      5'h05
`define SMRC_BURST_CLKS    5'h04
`define SMRC_DELAY_DEPTH   16

// ==========================================================================
// apb register map (byte offsets) and reset values
`define SMRC_PADDR_W       8
`define SMRC_OFF_CTRL      8'h00
`define SMRC_OFF_MODE_ONE  8'h04
`define SMRC_OFF_MODE_TWO  8'h08
`define SMRC_OFF_LAT       8'h0C
`define SMRC_OFF_STATUS    8'h10
`define SMRC_RCL_RST       4'h6

`endif

// File: src/smrc_pkg.sv
`include "smrc_defs.svh"

package smrc_pkg;

    typedef enum logic [1:0] {
        SMRC_CMD_NOP,
        SMRC_CMD_MRS,
        SMRC_CMD_READ,
        SMRC_CMD_WRITE
    } smrc_cmd_e;

    typedef struct packed {
        logic                     valid;
        smrc_cmd_e                kind;
        logic [1:0]               mode_sel;
        logic [`SMRC_ADDR_W-1:0]  addr;
    } smrc_cmd_s;

    typedef struct packed {
        logic [1:0] drive_sel;
        logic       out_tristate;
        logic       tstrobe_en;
        logic       data_mask_en;
        logic       write_level_en;
        logic       auto_sr_en;
        logic       refresh_2x;
        logic       term_active;
        logic [3:0] dq_term_div;
        logic [3:0] strobe_term_div;
        logic [4:0] read_lat;
        logic [4:0] write_lat;
    } smrc_cfg_s;

endpackage

// File: src/smrc_latency_delay.sv
`timescale 1ns/1ps
`default_nettype none
`include "smrc_defs.svh"

module smrc_latency_delay
    import smrc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic       rd_in,
    input  wire logic       wr_in,
    input  wire logic [3:0] addlat,
    output logic            rel_rd_q,
    output logic            rel_wr_q
);

    // ======================================================================
    // delay line, one stage per clock of additive latency
    logic [`SMRC_DELAY_DEPTH-1:0] rd_sr_q;
    logic [`SMRC_DELAY_DEPTH-1:0] rd_sr_d;
    logic [`SMRC_DELAY_DEPTH-1:0] wr_sr_q;
    logic [`SMRC_DELAY_DEPTH-1:0] wr_sr_d;
    logic                         rel_rd_d;
    logic                         rel_wr_d;

    always_comb
    begin
        rd_sr_d = {rd_sr_q[`SMRC_DELAY_DEPTH-2:0], rd_in};
        wr_sr_d = {wr_sr_q[`SMRC_DELAY_DEPTH-2:0], wr_in};
        // a zero latency command is released on the edge that takes it
        if (addlat == 4'h0)
        begin
            rel_rd_d = rd_in;
            rel_wr_d = wr_in;
        end
        else
        begin
            rel_rd_d = rd_sr_q[addlat - 4'h1];
            rel_wr_d = wr_sr_q[addlat - 4'h1];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_sr_q  <= '0;
            wr_sr_q  <= '0;
            rel_rd_q <= 1'b0;
            rel_wr_q <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_sr_q  <= rd_sr_d;
            wr_sr_q  <= wr_sr_d;
            rel_rd_q <= rel_rd_d;
            rel_wr_q <= rel_wr_d;
        end
    end

    a_release_no_delay: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && wr_in && addlat == 4'h0 |=> rel_wr_q)
        else $error("write with zero additive latency not released next cycle");

    a_release_five_delay: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && rd_in && addlat == 4'h5) ##1 (clk_en && addlat == 4'h5) [*5] |=> rel_rd_q)
        else $error("read with additive latency five not released on time");

endmodule
`default_nettype wire

// File: src/smrc_top.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "smrc_defs.svh"

module smrc_top
    import smrc_pkg::*;
(
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     clk_en,
    input  wire logic                     reset_pin_n,
    input  wire smrc_cmd_s                cmd,
    input  wire logic                     odt_pin,
    input  wire logic                     temp_high,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`SMRC_PADDR_W-1:0] paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    output smrc_cfg_s                     cfg,
    output logic                          int_read,
    output logic                          int_write
);

    // ======================================================================
    // state
    logic [`SMRC_ADDR_W-1:0] mode_one_q;
    logic [`SMRC_ADDR_W-1:0] mode_one_d;
    logic [`SMRC_ADDR_W-1:0] mode_two_q;
    logic [`SMRC_ADDR_W-1:0] mode_two_d;
    logic [3:0]              rcl_q;
    logic [3:0]              rcl_d;
    logic [4:0]              wwin_q;
    logic [4:0]              wwin_d;
    smrc_cfg_s               cfg_q;
    smrc_cfg_s               cfg_d;
    logic [31:0]             prdata_q;
    logic [31:0]             prdata_d;
    logic                    pslverr_q;
    logic                    pslverr_d;
    logic                    pready_q;

    logic [3:0]              addlat;
    logic [4:0]              wcl;
    logic [4:0]              rdlat;
    logic [4:0]              wrlat;
    logic [3:0]              nom_div;
    logic [3:0]              wr_div;
    logic [3:0]              applied_div;
    logic                    in_write;
    logic                    mrs_one;
    logic                    mrs_two;
    logic                    apb_setup;
    logic                    apb_wr;
    logic                    rel_rd;
    logic                    rel_wr;

    // ======================================================================
    // internal command release
    smrc_latency_delay u_delay (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clk_en   (clk_en),
        .rd_in    (cmd.valid && cmd.kind == SMRC_CMD_READ),
        .wr_in    (cmd.valid && cmd.kind == SMRC_CMD_WRITE),
        .addlat   (addlat),
        .rel_rd_q (rel_rd),
        .rel_wr_q (rel_wr)
    );

    // ======================================================================
    // field decode
    always_comb
    begin
        unique case (mode_one_q[`SMRC_ONE_ADDLAT_HI:`SMRC_ONE_ADDLAT_LO])
            2'h1:    addlat = rcl_q - 4'h1;
            2'h2:    addlat = rcl_q - 4'h2;
            default: addlat = 4'h0;
        endcase
        wcl   = `SMRC_WCL_BASE + {2'h0, mode_two_q[`SMRC_TWO_WCL_HI:`SMRC_TWO_WCL_LO]};
        rdlat = {1'h0, addlat} + {1'h0, rcl_q};
        wrlat = {1'h0, addlat} + wcl;
        unique case ({mode_one_q[9], mode_one_q[6], mode_one_q[2]})
            3'h1:    nom_div = 4'h4;
            3'h2:    nom_div = 4'h2;
            3'h3:    nom_div = 4'h6;
            3'h4:    nom_div = 4'hC;
            3'h5:    nom_div = 4'h8;
            default: nom_div = 4'h0;
        endcase
        unique case (mode_two_q[`SMRC_TWO_WTERM_HI:`SMRC_TWO_WTERM_LO])
            2'h1:    wr_div = 4'h4;
            2'h2:    wr_div = 4'h2;
            default: wr_div = 4'h0;
        endcase
    end

    // ======================================================================
    // mode registers, write window and outputs
    always_comb
    begin
        mrs_one    = cmd.valid && cmd.kind == SMRC_CMD_MRS && cmd.mode_sel == `SMRC_SEL_ONE;
        mrs_two    = cmd.valid && cmd.kind == SMRC_CMD_MRS && cmd.mode_sel == `SMRC_SEL_TWO;
        mode_one_d = mode_one_q;
        mode_two_d = mode_two_q;
        // whole word loaded at once, other register untouched
        if (!reset_pin_n)
            mode_one_d = '0;
        else if (mrs_one)
            mode_one_d = cmd.addr;
        // reset pin does not clear this one; only power-on does
        if (mrs_two)
            mode_two_d = cmd.addr;

        // window covers write CAS latency plus the burst itself
        if (rel_wr)
            wwin_d = wcl + `SMRC_BURST_CLKS;
        else if (wwin_q != 5'h00)
            wwin_d = wwin_q - 5'h01;
        else
            wwin_d = 5'h00;
        in_write = wwin_q != 5'h00;

        // dynamic termination is unavailable while write leveling
        if (in_write && wr_div != 4'h0 && !mode_one_q[`SMRC_ONE_WLEVEL])
            applied_div = wr_div;
        else
            applied_div = nom_div;

        cfg_d                 = cfg_q;
        cfg_d.drive_sel       = {mode_one_q[5], mode_one_q[1]};
        cfg_d.out_tristate    = mode_one_q[`SMRC_ONE_QOFF];
        cfg_d.tstrobe_en      = mode_one_q[`SMRC_ONE_TSTROBE];
        cfg_d.data_mask_en    = !mode_one_q[`SMRC_ONE_TSTROBE];
        cfg_d.write_level_en  = mode_one_q[`SMRC_ONE_WLEVEL];
        cfg_d.auto_sr_en      = mode_two_q[`SMRC_TWO_AUTOSR];
        cfg_d.refresh_2x      = mode_two_q[`SMRC_TWO_AUTOSR] && temp_high;
        cfg_d.term_active     = odt_pin && applied_div != 4'h0;
        cfg_d.dq_term_div     = odt_pin ? applied_div : 4'h0;
        // strobe pins only ever terminate; there is no driver on them
        cfg_d.strobe_term_div = (odt_pin && mode_one_q[`SMRC_ONE_TSTROBE]) ?
                                applied_div : 4'h0;
        cfg_d.read_lat        = rdlat;
        cfg_d.write_lat       = wrlat;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_one_q <= '0;
            mode_two_q <= '0;
            wwin_q     <= 5'h00;
            // reset view matches cleared mode registers: mask ball active, default latencies
            cfg_q      <= '{data_mask_en: 1'b1, read_lat: {1'b0, `SMRC_RCL_RST},
                            write_lat: `SMRC_WCL_BASE, default: '0};
        end
        else if (clk_en)
        begin
            mode_one_q <= mode_one_d;
            mode_two_q <= mode_two_d;
            wwin_q     <= wwin_d;
            cfg_q      <= cfg_d;
        end
    end

    // ======================================================================
    // apb slave: zero wait, read data captured in the setup cycle
    always_comb
    begin
        apb_setup = psel && !penable;
        apb_wr    = psel && penable && pwrite && pready_q;
        rcl_d     = rcl_q;
        if (apb_wr && paddr == `SMRC_OFF_CTRL)
            rcl_d = pwdata[3:0];
        prdata_d  = prdata_q;
        pslverr_d = pslverr_q;
        if (apb_setup)
        begin
            pslverr_d = 1'b0;
            unique case (paddr)
                `SMRC_OFF_CTRL:     prdata_d = {28'h000_0000, rcl_q};
                `SMRC_OFF_MODE_ONE: prdata_d = {14'h0000, mode_one_q};
                `SMRC_OFF_MODE_TWO: prdata_d = {14'h0000, mode_two_q};
                `SMRC_OFF_LAT:      prdata_d = {12'h000, addlat, 3'h0, wrlat, 3'h0, rdlat};
                `SMRC_OFF_STATUS:   prdata_d = {24'h00_0000, cfg_q.term_active,
                                                cfg_q.refresh_2x, cfg_q.auto_sr_en,
                                                cfg_q.write_level_en, cfg_q.tstrobe_en,
                                                cfg_q.out_tristate, cfg_q.drive_sel};
                default:
                begin
                    prdata_d  = 32'h0000_0000;
                    pslverr_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            rcl_q     <= `SMRC_RCL_RST;
            prdata_q  <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            pready_q  <= 1'b1;
        end
        else if (clk_en)
        begin
            rcl_q     <= rcl_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
            pready_q  <= 1'b1;
        end
    end

    assign prdata    = prdata_q;
    assign pslverr   = pslverr_q;
    assign pready    = pready_q;
    assign cfg       = cfg_q;
    assign int_read  = rel_rd;
    assign int_write = rel_wr;

    // ======================================================================
    // checks
    a_tristate_from_mrs: assert property (@(posedge sys_clk) disable iff (rst)
        (clk_en && mrs_one && reset_pin_n) ##1 clk_en |=>
        cfg_q.out_tristate == $past(cmd.addr[`SMRC_ONE_QOFF], 2))
        else $error("output disable did not follow mode set");

    a_mask_vs_strobe: assert property (@(posedge sys_clk) disable iff (rst)
        cfg_q.data_mask_en != cfg_q.tstrobe_en)
        else $error("data mask and termination strobe both on or both off");

    a_strobe_no_term: assert property (@(posedge sys_clk) disable iff (rst)
        !cfg_q.tstrobe_en |-> cfg_q.strobe_term_div == 4'h0)
        else $error("termination strobe pair terminated while feature off");

    a_term_needs_pin: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !odt_pin |=> !cfg_q.term_active && cfg_q.dq_term_div == 4'h0)
        else $error("termination on without termination pin");

    a_wlevel_follow: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en |=> cfg_q.write_level_en == $past(mode_one_q[`SMRC_ONE_WLEVEL]))
        else $error("write leveling enable does not follow mode register");

    a_read_lat_sum: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && mode_one_q[4:3] == 2'h1 |=>
        cfg_q.read_lat == ({1'h0, $past(rcl_q)} << 1) - 5'h01)
        else $error("read latency wrong with additive latency one less");

    a_write_lat_sum: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && mode_one_q[4:3] == 2'h0 |=>
        cfg_q.write_lat == 5'h05 + {2'h0, $past(mode_two_q[5:3])})
        else $error("write latency wrong with zero additive latency");

    a_reset_pin_clear: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !reset_pin_n |=> mode_one_q == '0)
        else $error("reset pin did not clear mode register one");

    a_mrs_one_only: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && mrs_one && reset_pin_n |=>
        mode_one_q == $past(cmd.addr) && mode_two_q == $past(mode_two_q))
        else $error("mode set disturbed the register it did not address");

    a_autosr_off: assert property (@(posedge sys_clk) disable iff (rst)
        clk_en && !mode_two_q[`SMRC_TWO_AUTOSR] |=> !cfg_q.refresh_2x)
        else $error("refresh rate doubled with auto self refresh off");

endmodule
`default_nettype wire

// File: bench/smrc_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "smrc_defs.svh"

module smrc_ctrl_model
    import smrc_pkg::*;
#(
    parameter int MOD_CLKS  = 12,
    parameter int RCD_CLKS  = 6,
    parameter bit BY8       = 1'b1,
    parameter bit DIE_REV_A = 1'b0
)
(
    input  wire logic sys_clk,
    output var  smrc_cmd_s cmd
);
    // ==========================================================================
    // command issue
    initial cmd = '0;

    task automatic send(input smrc_cmd_e kd, input logic [1:0] sel,
                        input logic [`SMRC_ADDR_W-1:0] a);
        // bank counts as opened at the previous command; waiting the whole
        // row-to-column delay keeps gap plus latency legal for any latency
        if (kd == SMRC_CMD_READ || kd == SMRC_CMD_WRITE)
            repeat (RCD_CLKS) @(posedge sys_clk);
        @(posedge sys_clk);
        cmd <= '{valid: 1'b1, kind: kd, mode_sel: sel, addr: a};
        @(posedge sys_clk);
        // released lines show the inverse so a stale copy can never pass
        cmd <= '{valid: 1'b0, kind: SMRC_CMD_NOP, mode_sel: ~sel, addr: ~a};
    endtask

    task automatic mrs(input logic [1:0] sel, input logic [`SMRC_ADDR_W-1:0] a);
        logic [`SMRC_ADDR_W-1:0] v;
        v = a;
        if (sel == `SMRC_SEL_ONE)
        begin
            v = v & ~18'h2_6500;
            if (!BY8) v[`SMRC_ONE_TSTROBE] = 1'b0;
        end
        else
        begin
            v = v & ~18'h2_7907;
            if (DIE_REV_A) v[`SMRC_TWO_AUTOSR] = 1'b0;
        end
        send(SMRC_CMD_MRS, sel, v);
        // all banks idle here; wait out the command and update delays
        repeat (MOD_CLKS) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "smrc_defs.svh"

module tb_top
    import smrc_pkg::*;
;
    logic                     sys_clk, rst, clk_en, reset_pin_n, odt_pin, temp_high;
    logic                     psel, penable, pwrite, pready, pslverr, err;
    logic [`SMRC_PADDR_W-1:0] paddr;
    logic [31:0]              pwdata, prdata, rd;
    logic                     int_read, int_write;
    smrc_cmd_s                cmd;
    smrc_cfg_s                cfg;
    int                       errors, comparisons, k, al;
    logic [3:0]               divs [8] = '{4'h0, 4'h4, 4'h2, 4'h6, 4'hC, 4'h8, 4'h0, 4'h0};

    smrc_top i_smrc_top (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en),
        .reset_pin_n(reset_pin_n), .cmd(cmd), .odt_pin(odt_pin), .temp_high(temp_high),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg),
        .int_read(int_read), .int_write(int_write));
    smrc_ctrl_model i_smrc_ctrl_model (.sys_clk(sys_clk), .cmd(cmd));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ==========================================================================
    // access tasks
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        // waits until pready is high; the watchdog ends a hang
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, rd, exp);
    endtask

    // counts edges from the take edge to the internal release pulse
    task automatic lat(input smrc_cmd_e kd, output int n);
        i_smrc_ctrl_model.send(kd, 2'h0, 18'h0_0000);
        n = 0;
        #1;
        while (((kd == SMRC_CMD_READ) ? int_read : int_write) !== 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
    endtask

    task automatic results();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // ==========================================================================
    // watchdog
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("BAD watchdog expected done seen hang");
        results();
    end

    // ==========================================================================
    // tests
    initial
    begin
        errors = 0;
        comparisons = 0;
        rst = 1'b1;
        clk_en = 1'b1;
        reset_pin_n = 1'b1;
        odt_pin = 1'b0;
        temp_high = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;

        rchk("ctrl", 8'h00, 32'h0000_0006);
        rchk("mode one", 8'h04, 32'h0);
        rchk("mode two", 8'h08, 32'h0);
        rchk("lat", 8'h0C, 32'h0000_0506);
        rchk("status", 8'h10, 32'h0);
        rchk("unmapped", 8'h14, 32'h0);
        chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        chk("ro err", {31'h0, err}, 32'h0);
        rchk("ro kept", 8'h04, 32'h0);
        apb(1'b1, 8'h00, 32'hFFFF_FFF7);
        rchk("ctrl rw", 8'h00, 32'h0000_0007);
        $display("test registers done");

        i_smrc_ctrl_model.mrs(2'h1, 18'h0_1882);
        rchk("mode one", 8'h04, 32'h0000_1882);
        rchk("status a", 8'h10, 32'h0000_001D);
        chk("mask off", {31'h0, cfg.data_mask_en}, 32'h0);
        i_smrc_ctrl_model.mrs(2'h1, 18'h0_0020);
        rchk("status b", 8'h10, 32'h0000_0002);
        chk("mask on", {31'h0, cfg.data_mask_en}, 32'h1);
        $display("test mode one fields done");

        i_smrc_ctrl_model.mrs(2'h2, 18'h0_0010);
        for (int c = 0; c < 4; c++)
        begin
            al = (c == 1) ? 6 : (c == 2) ? 5 : 0;
            i_smrc_ctrl_model.mrs(2'h1, 18'(c << 3));
            rchk("lat", 8'h0C, {12'h0, al[3:0], 3'h0, 5'(al + 7), 3'h0, 5'(al + 7)});
            chk("cfg lat", {22'h0, cfg.write_lat, cfg.read_lat},
                {22'h0, 5'(al + 7), 5'(al + 7)});
            lat(SMRC_CMD_READ, k);
            chk("read hold", 32'(k), 32'(al));
            lat(SMRC_CMD_WRITE, k);
            chk("write hold", 32'(k), 32'(al));
        end
        $display("test latency done");

        @(posedge sys_clk);
        odt_pin <= 1'b1;
        for (int c = 0; c < 8; c++)
        begin
            i_smrc_ctrl_model.mrs(2'h1, 18'h0_0800 | 18'({c[2], 2'b00, c[1], 3'b000, c[0], 2'b00}));
            chk("nominal", {28'h0, cfg.dq_term_div}, {28'h0, divs[c]});
            chk("strobe term", {28'h0, cfg.strobe_term_div}, {28'h0, divs[c]});
            chk("term on", {31'h0, cfg.term_active}, {31'h0, divs[c] != 4'h0});
        end
        @(posedge sys_clk);
        odt_pin <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("term off", {31'h0, cfg.term_active}, 32'h0);
        odt_pin <= 1'b1;
        i_smrc_ctrl_model.mrs(2'h2, 18'h0_0200);
        for (int w = 0; w < 2; w++)
        begin
            i_smrc_ctrl_model.mrs(2'h1, w ? 18'h0_00C0 : 18'h0_0040);
            lat(SMRC_CMD_WRITE, k);
            // window opens one edge after the release, cfg follows one edge later
            repeat (2) @(posedge sys_clk);
            #1;
            chk("write term", {28'h0, cfg.dq_term_div}, w ? 32'h2 : 32'h4);
            // window is write CAS latency 5 plus 4 burst clocks
            repeat (8) @(posedge sys_clk);
            #1;
            chk("write term end", {28'h0, cfg.dq_term_div}, w ? 32'h2 : 32'h4);
            @(posedge sys_clk);
            #1;
            chk("after write", {28'h0, cfg.dq_term_div}, 32'h2);
        end
        $display("test termination done");
        @(posedge sys_clk);

        temp_high <= 1'b1;
        i_smrc_ctrl_model.mrs(2'h1, 18'h0_0000);
        i_smrc_ctrl_model.mrs(2'h2, 18'h0_0040);
        rchk("refresh hot", 8'h10, 32'h0000_0060);
        temp_high <= 1'b0;
        rchk("refresh cool", 8'h10, 32'h0000_0020);
        i_smrc_ctrl_model.mrs(2'h1, 18'h0_1000);
        i_smrc_ctrl_model.mrs(2'h3, 18'h0_0008);
        rchk("two kept", 8'h08, 32'h0000_0040);
        rchk("one kept", 8'h04, 32'h0000_1000);
        @(posedge sys_clk);
        reset_pin_n <= 1'b0;
        @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        rchk("one cleared", 8'h04, 32'h0);
        rchk("two survives", 8'h08, 32'h0000_0040);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        i_smrc_ctrl_model.mrs(2'h1, 18'h0_0020);
        clk_en <= 1'b1;
        rchk("frozen", 8'h04, 32'h0);
        $display("test refresh and reset pin done");
        results();
    end
endmodule
`default_nettype wire
